// File: verilog/idle_gating_defines.vh
`ifndef IDLE_GATING_DEFINES_VH
`define IDLE_GATING_DEFINES_VH

// register bus geometry
`define ADDR_W          4
`define DATA_W          16

// register offsets
`define OFF_IDLE_CFG    4'h1
`define OFF_IDLE_STAT   4'h2
`define OFF_PG_ONE      4'h3
`define OFF_PG_TWO      4'h4
`define OFF_GATE_VIEW   4'h5

// idle configuration / status field positions
`define BIT_CPU         0
`define CFG_FIELD_LSB   1
`define CFG_FIELD_MSB   4
`define BIT_DATA        5
`define BIT_IO          6
`define BIT_MEM         7
`define BIT_INSTR       8
`define BIT_ACCEL       9

// peripheral gating one: bit 15 is the global clock disable
`define BIT_GLOBAL      15
`define PERIPH_COUNT    31

// writable and readable masks
`define CFG_WMASK       16'h03ff
`define STAT_RMASK      16'h03e1
`define PG_ONE_WMASK    16'hffff
`define PG_TWO_WMASK    16'hffff

// reset values
`define CFG_RST         16'h0000
`define STAT_RST        16'h0000
`define PG_ONE_RST      16'h0000
`define PG_TWO_RST      16'h0000
`define RDATA_RST       16'h0000

// cpu domain count and gate view layout
`define DOMAIN_COUNT    6
`define VIEW_PEND_BIT   15
`define VIEW_EMU_BIT    14
`define VIEW_CHIP_BIT   13

`endif

// File: verilog/cpu_idle_clock_gate.v
// Functional notes
// - configuration waits for the idle instruction
// - idle copies configuration into status, drives gates
// - peripheral gating writes act at once
// - global disable gates chip except clock sources
// - idle method covers cpu, four ports, accelerator
// - ports: fetch, data, io, memory for dma
// - a small always-on part keeps its clock
// - attached emulator overrides cpu domain idle
// - configuration read/write, reset zero, fixed bit map
// - status read-only, shows state at last idle until a wake clears it
// - idle bit one disables, zero keeps active
`timescale 1ns/1ps
`include "idle_gating_defines.vh"

module cpu_idle_clock_gate (
    input  wire                      CLK_I,
    input  wire                      NRST_I,
    input  wire [`ADDR_W-1:0]        ADDR_I,
    input  wire [`DATA_W-1:0]        WDATA_I,
    input  wire                      WR_I,
    input  wire                      RD_I,
    output reg  [`DATA_W-1:0]        RDATA_O,
    input  wire                      IDLE_EXEC_I,
    input  wire                      WAKE_I,
    input  wire                      EMU_ATTACHED_I,
    output reg                       CPU_CLK_EN_O,
    output reg                       FETCH_PORT_CLK_EN_O,
    output reg                       DATA_PORT_CLK_EN_O,
    output reg                       IO_PORT_CLK_EN_O,
    output reg                       MEM_PORT_CLK_EN_O,
    output reg                       ACCEL_CLK_EN_O,
    output reg  [`PERIPH_COUNT-1:0]  PERIPH_CLK_EN_O,
    output reg                       CHIP_CLK_EN_O,
    output reg                       ALWAYS_ON_CLK_EN_O
);

    // configuration staged by software
    reg  [`DATA_W-1:0]       idle_configuration;
    // state applied at the last idle instruction, or cleared by the last wake
    reg  [`DATA_W-1:0]       idle_status;
    reg  [`DATA_W-1:0]       peripheral_gating_one;
    reg  [`DATA_W-1:0]       peripheral_gating_two;
    // configuration written but not yet applied
    reg                      cfg_pending;

    reg                      emu_meta;
    reg                      emu_sync;

    wire                     global_clock_disable;
    wire [`DOMAIN_COUNT-1:0] domain_idle;
    wire [`DOMAIN_COUNT-1:0] domain_gated;
    wire [`PERIPH_COUNT-1:0] periph_off;
    wire [`PERIPH_COUNT-1:0] next_periph_en;

    wire                     wr_cfg;
    wire                     wr_pg_one;
    wire                     wr_pg_two;

    reg  [`DATA_W-1:0]       next_rdata;
    reg  [`DATA_W-1:0]       gate_view;

    assign wr_cfg    = WR_I && (ADDR_I == `OFF_IDLE_CFG);
    assign wr_pg_one = WR_I && (ADDR_I == `OFF_PG_ONE);
    assign wr_pg_two = WR_I && (ADDR_I == `OFF_PG_TWO);

    // jtag presence comes from a pin: two flops before use
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            emu_meta <= 1'b0;
            emu_sync <= 1'b0;
        end else begin
            emu_meta <= EMU_ATTACHED_I;
            emu_sync <= emu_meta;
        end
    end

    // staged configuration; no gate looks at it directly
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            idle_configuration <= `CFG_RST;
        end else if (wr_cfg) begin
            idle_configuration <= WDATA_I & `CFG_WMASK;
        end
    end

    // pending flag: a write in the idle cycle counts as new,
    // so the set wins over the clear done by the idle copy
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cfg_pending <= 1'b0;
        end else if (wr_cfg) begin
            cfg_pending <= 1'b1;
        end else if (IDLE_EXEC_I) begin
            cfg_pending <= 1'b0;
        end
    end

    // idle copies the whole configuration; wake brings all back up.
    // a write in the same cycle as idle is not yet seen by the copy
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            idle_status <= `STAT_RST;
        end else if (IDLE_EXEC_I) begin
            idle_status <= idle_configuration;
        end else if (WAKE_I) begin
            idle_status <= `STAT_RST;
        end
    end

    // peripheral gating registers take effect with no idle needed
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            peripheral_gating_one <= `PG_ONE_RST;
        end else if (wr_pg_one) begin
            peripheral_gating_one <= WDATA_I & `PG_ONE_WMASK;
        end else if (WAKE_I) begin
            // a wake event lifts the global disable only
            peripheral_gating_one[`BIT_GLOBAL] <= 1'b0;
        end
    end

    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            peripheral_gating_two <= `PG_TWO_RST;
        end else if (wr_pg_two) begin
            peripheral_gating_two <= WDATA_I & `PG_TWO_WMASK;
        end
    end

    assign global_clock_disable = peripheral_gating_one[`BIT_GLOBAL];

    // cpu domain idle bits in a fixed order:
    // 0 cpu, 1 fetch port, 2 data port, 3 io port, 4 memory port, 5 accelerator
    assign domain_idle = {
        idle_status[`BIT_ACCEL],
        idle_status[`BIT_MEM],
        idle_status[`BIT_IO],
        idle_status[`BIT_DATA],
        idle_status[`BIT_INSTR],
        idle_status[`BIT_CPU]
    };

    // one per domain: idle bit 1 stops it, emulator wins over idle,
    // global disable wins over everything
    genvar d;
    generate
        for (d = 0; d < `DOMAIN_COUNT; d = d + 1) begin : g_domain
            assign domain_gated[d] = global_clock_disable ||
                                     (domain_idle[d] && !emu_sync);
        end
    endgenerate

    // peripheral bits: one means clock stopped
    assign periph_off = {peripheral_gating_two,
                         peripheral_gating_one[`BIT_GLOBAL-1:0]};

    genvar p;
    generate
        for (p = 0; p < `PERIPH_COUNT; p = p + 1) begin : g_periph
            assign next_periph_en[p] = !(periph_off[p] || global_clock_disable);
        end
    endgenerate

    // gate enables from flops so each gate sees a clean level
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            CPU_CLK_EN_O        <= 1'b1;
            FETCH_PORT_CLK_EN_O <= 1'b1;
            DATA_PORT_CLK_EN_O  <= 1'b1;
            IO_PORT_CLK_EN_O    <= 1'b1;
            MEM_PORT_CLK_EN_O   <= 1'b1;
            ACCEL_CLK_EN_O      <= 1'b1;
        end else begin
            CPU_CLK_EN_O        <= !domain_gated[0];
            FETCH_PORT_CLK_EN_O <= !domain_gated[1];
            DATA_PORT_CLK_EN_O  <= !domain_gated[2];
            IO_PORT_CLK_EN_O    <= !domain_gated[3];
            MEM_PORT_CLK_EN_O   <= !domain_gated[4];
            ACCEL_CLK_EN_O      <= !domain_gated[5];
        end
    end

    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PERIPH_CLK_EN_O <= {`PERIPH_COUNT{1'b1}};
        end else begin
            PERIPH_CLK_EN_O <= next_periph_en;
        end
    end

    // this block itself, the clock sources and the wake path stay on,
    // which is why gated power is near zero rather than zero
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            CHIP_CLK_EN_O      <= 1'b1;
            ALWAYS_ON_CLK_EN_O <= 1'b1;
        end else begin
            CHIP_CLK_EN_O      <= !global_clock_disable;
            ALWAYS_ON_CLK_EN_O <= 1'b1;
        end
    end

    // live view of what the gates are being told
    always @* begin
        gate_view = {`DATA_W{1'b0}};
        gate_view[`DOMAIN_COUNT-1:0] = domain_gated;
        gate_view[`VIEW_CHIP_BIT]    = global_clock_disable;
        gate_view[`VIEW_EMU_BIT]     = emu_sync;
        gate_view[`VIEW_PEND_BIT]    = cfg_pending;
    end

    // read mux; unmapped addresses read zero
    always @* begin
        next_rdata = {`DATA_W{1'b0}};
        if (RD_I) begin
            case (ADDR_I)
                `OFF_IDLE_CFG:  next_rdata = idle_configuration;
                `OFF_IDLE_STAT: next_rdata = idle_status & `STAT_RMASK;
                `OFF_PG_ONE:    next_rdata = peripheral_gating_one;
                `OFF_PG_TWO:    next_rdata = peripheral_gating_two;
                `OFF_GATE_VIEW: next_rdata = gate_view;
                default:        next_rdata = {`DATA_W{1'b0}};
            endcase
        end
    end

    // read data stands only in the cycle after the strobe;
    // writes to status and gate view are dropped
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RDATA_O <= `RDATA_RST;
        end else begin
            RDATA_O <= next_rdata;
        end
    end

endmodule // cpu_idle_clock_gate

// File: sim/cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       req_i,
    input  wire [3:0] lag_i,
    output reg        idle_exec_o
);
    reg [4:0] cnt;
    // one idle pulse per request; lag_i models a slow core
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt         <= 5'h00;
            idle_exec_o <= 1'h0;
        end else begin
            idle_exec_o <= (cnt == 5'h01);
            if (req_i)
                cnt <= {1'h0, lag_i} + 5'h01;
            else if (cnt != 5'h00)
                cnt <= cnt - 5'h01;
        end
    end
endmodule // cpu_core_model

// File: sim/idle_gate_chk.sv
`timescale 1ns/1ps
`include "idle_gating_defines.vh"
module idle_gate_chk (
    input wire        CLK_I,
    input wire        NRST_I,
    input wire [3:0]  ADDR_I,
    input wire [15:0] WDATA_I,
    input wire        WR_I,
    input wire        RD_I,
    input wire [15:0] RDATA_O,
    input wire        IDLE_EXEC_I,
    input wire        WAKE_I,
    input wire        EMU_ATTACHED_I,
    input wire [5:0]  DOM,
    input wire [30:0] PERIPH_CLK_EN_O,
    input wire        CHIP_CLK_EN_O,
    input wire        ALWAYS_ON_CLK_EN_O
);
    reg [15:0] cfg;
    reg [15:0] stat;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cfg  <= 16'h0000;
            stat <= 16'h0000;
        end else begin
            if (WR_I && ADDR_I == `OFF_IDLE_CFG)
                cfg <= WDATA_I & `CFG_WMASK;
            if (IDLE_EXEC_I)
                stat <= cfg;
            else if (WAKE_I)
                stat <= 16'h0000;
        end
    end
    sequence idle_go;
        IDLE_EXEC_I && !WAKE_I && !WR_I && !EMU_ATTACHED_I && !$past(EMU_ATTACHED_I);
    endsequence
    sequence calm;
        !IDLE_EXEC_I && !WAKE_I && !WR_I;
    endsequence
    chk_cfg_held: assert property ((WR_I && ADDR_I == `OFF_IDLE_CFG && !IDLE_EXEC_I)
        ##1 calm |=> $stable(DOM)) else $error("gates moved on config write");
    chk_idle_apply: assert property (idle_go ##1 calm |=>
        !CHIP_CLK_EN_O || DOM == ~{stat[9:5], stat[0]}) else $error("idle gates wrong");
    chk_global_off: assert property (!CHIP_CLK_EN_O |-> DOM == 6'h00 &&
        PERIPH_CLK_EN_O == 31'h0) else $error("global disable leaks");
    chk_always_on: assert property (ALWAYS_ON_CLK_EN_O)
        else $error("always-on clock stopped");
    chk_periph_now: assert property ((WR_I && ADDR_I == `OFF_PG_TWO) ##1 !WR_I |=>
        !CHIP_CLK_EN_O || PERIPH_CLK_EN_O[30:15] == ~$past(WDATA_I, 2))
        else $error("peripheral gate late");
    chk_cfg_read: assert property (RD_I && ADDR_I == `OFF_IDLE_CFG |=>
        RDATA_O == $past(cfg)) else $error("config readback wrong");
    chk_stat_read: assert property (RD_I && ADDR_I == `OFF_IDLE_STAT |=>
        RDATA_O == ($past(stat) & `STAT_RMASK)) else $error("status readback wrong");
    chk_emu_keeps: assert property (EMU_ATTACHED_I [*4] |->
        DOM[0] || !CHIP_CLK_EN_O) else $error("cpu stopped under emulator");
endmodule // idle_gate_chk
bind cpu_idle_clock_gate idle_gate_chk i_idle_gate_chk (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IDLE_EXEC_I(IDLE_EXEC_I),
    .WAKE_I(WAKE_I), .EMU_ATTACHED_I(EMU_ATTACHED_I),
    .DOM({ACCEL_CLK_EN_O, FETCH_PORT_CLK_EN_O, MEM_PORT_CLK_EN_O,
        IO_PORT_CLK_EN_O, DATA_PORT_CLK_EN_O, CPU_CLK_EN_O}),
    .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O), .CHIP_CLK_EN_O(CHIP_CLK_EN_O),
    .ALWAYS_ON_CLK_EN_O(ALWAYS_ON_CLK_EN_O));

// File: sim/tb_top.sv
`timescale 1ns/1ps
`include "idle_gating_defines.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    reg         clk = 1'h0;
    reg         nrst = 1'h0;
    reg  [3:0]  addr = 4'h0;
    reg  [15:0] wdata = 16'h0;
    reg         wr = 1'h0;
    reg         rd = 1'h0;
    reg         wake = 1'h0;
    reg         emu = 1'h0;
    reg         req = 1'h0;
    reg  [3:0]  lag = 4'h0;
    reg  [3:0]  i;
    reg  [15:0] d;
    wire [15:0] rdata;
    wire        idle, cpu, fet, dp, io, mem, acc, chip, aon;
    wire [30:0] periph;
    wire [5:0]  dom = {acc, fet, mem, io, dp, cpu};
    integer     error_cnt = 0;
    integer     checks = 0;
    integer     cyc = 0;
    always #2 clk = ~clk;
    cpu_core_model i_cpu_core_model (.clk_i(clk), .nrst_i(nrst), .req_i(req),
        .lag_i(lag), .idle_exec_o(idle));
    cpu_idle_clock_gate i_cpu_idle_clock_gate (.CLK_I(clk), .NRST_I(nrst),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .IDLE_EXEC_I(idle), .WAKE_I(wake), .EMU_ATTACHED_I(emu),
        .CPU_CLK_EN_O(cpu), .FETCH_PORT_CLK_EN_O(fet), .DATA_PORT_CLK_EN_O(dp),
        .IO_PORT_CLK_EN_O(io), .MEM_PORT_CLK_EN_O(mem), .ACCEL_CLK_EN_O(acc),
        .PERIPH_CLK_EN_O(periph), .CHIP_CLK_EN_O(chip), .ALWAYS_ON_CLK_EN_O(aon));
    task wr_reg(input [3:0] a, input [15:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'h1;
        @(posedge clk);
        wr    <= 1'h0;
    endtask
    task rd_reg(input [3:0] a, input [15:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clk);
        rd   <= 1'h0;
        #1 `CHK(rdata, e)
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // the core reaches idle lag plus one cycles after the request is sampled
    task run_idle(input [3:0] l);
        @(posedge clk);
        lag <= l;
        req <= 1'h1;
        @(posedge clk);
        req <= 1'h0;
        repeat (l + 5) @(posedge clk);
        #1;
    endtask
    task pulse_wake;
        @(posedge clk);
        wake <= 1'h1;
        @(posedge clk);
        wake <= 1'h0;
        settle;
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            error_cnt = error_cnt + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'h1;
        rd_reg(`OFF_IDLE_CFG, 16'h0000);
        rd_reg(`OFF_IDLE_STAT, 16'h0000);
        rd_reg(4'hf, 16'h0000);
        `CHK({dom, chip, aon, periph}, {8'hff, 31'h7fffffff})
        $display("test reset done");
        wr_reg(`OFF_PG_ONE, 16'h7fff);
        wr_reg(`OFF_PG_TWO, 16'hffff);
        settle;
        `CHK(periph, 31'h0)
        wr_reg(`OFF_PG_TWO, 16'h8001);
        wr_reg(`OFF_PG_ONE, 16'h0005);
        settle;
        `CHK(periph, ~{16'h8001, 15'h0005})
        $display("test peripheral done");
        wr_reg(`OFF_IDLE_CFG, 16'hffff);
        settle;
        `CHK(dom, 6'h3f)
        rd_reg(`OFF_IDLE_CFG, 16'h03ff);
        rd_reg(`OFF_IDLE_STAT, 16'h0000);
        for (i = 4'h0; i < 4'h6; i = i + 4'h1) begin
            d = 16'h000e | (16'h0001 << (i != 4'h0 ? i + 4'h4 : 4'h0));
            wr_reg(`OFF_IDLE_CFG, d);
            run_idle(i + i);
            `CHK(dom, ~(6'h01 << i))
            rd_reg(`OFF_IDLE_STAT, d & 16'h03e1);
            pulse_wake;
            rd_reg(`OFF_IDLE_STAT, 16'h0000);
        end
        `CHK(dom, 6'h3f)
        $display("test idle done");
        wr_reg(`OFF_PG_ONE, 16'h8000);
        settle;
        `CHK({chip, aon, dom, periph}, {2'h1, 37'h0})
        rd_reg(`OFF_GATE_VIEW, 16'h203f);
        pulse_wake;
        `CHK(chip, 1'h1)
        rd_reg(`OFF_PG_ONE, 16'h0000);
        wr_reg(`OFF_PG_ONE, 16'h0000);
        settle;
        `CHK(chip, 1'h1)
        $display("test global done");
        @(posedge clk) emu <= 1'h1;
        wr_reg(`OFF_IDLE_CFG, 16'h000f);
        rd_reg(`OFF_GATE_VIEW, 16'hc000);
        run_idle(4'h0);
        `CHK(cpu, 1'h1)
        rd_reg(`OFF_GATE_VIEW, 16'h4000);
        rd_reg(`OFF_IDLE_STAT, 16'h0001);
        wr_reg(`OFF_IDLE_STAT, 16'hffff);
        rd_reg(`OFF_IDLE_STAT, 16'h0001);
        @(posedge clk) emu <= 1'h0;
        pulse_wake;
        `CHK(dom, 6'h3f)
        $display("test emulator done");
        give_verdict;
    end
endmodule // tb_top
